// ===== common/tcm_defines.svh
// field positions, sizes and reset values of the time-slot switch control block
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

// frame geometry
`define TCM_NUM_STREAMS    8
`define TCM_NUM_CH         32
`define TCM_FIFO_DEPTH     32

// channel output control word bit positions
`define TCM_CCM_VC         6
`define TCM_CCM_MC         2
`define TCM_CCM_CSO        1
`define TCM_CCM_OE         0

// channel source select word field positions
`define TCM_SRC_STR_MSB    7
`define TCM_SRC_STR_LSB    5
`define TCM_SRC_CH_MSB     4
`define TCM_SRC_CH_LSB     0

// synchronised pin vector: {gate, frame_n, bit_clk, stream_in[7:0]}
`define TCM_PIN_GATE       10
`define TCM_PIN_FRAME      9
`define TCM_PIN_BCLK       8
`define TCM_PIN_RST        11'h200

`endif

// ===== common/tcm_pkg.sv
// types shared by the time-slot switch control block
package tcm_pkg;

  // which per-channel memory a processor access targets
  typedef enum logic {
    TCM_MEM_SOURCE  = 1'b0,
    TCM_MEM_CONTROL = 1'b1
  } tcm_mem_sel_t;

  // processor port handshake states
  typedef enum logic [1:0] {
    TCM_CPU_IDLE = 2'b01,
    TCM_CPU_DONE = 2'b10
  } tcm_cpu_state_t;

  // one queued memory write
  typedef struct packed {
    tcm_mem_sel_t sel;
    logic [7:0]   addr;
    logic [7:0]   data;
  } tcm_wr_t;

endpackage

// ===== common/tcm_fifo_if.sv
// valid/ready carrier between the write queue and its filler and drainer
`timescale 1ns/1ps
interface tcm_fifo_if #(
  parameter int WIDTH = 17
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport filler  (output in_valid, output in_data, input in_ready);
  modport store   (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
  modport drainer (input out_valid, input out_data, output out_ready);
endinterface

// ===== hdl/tcm_fifo.sv
// parameterised first-in first-out queue with valid/ready on both sides
`timescale 1ns/1ps
module tcm_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // queue sides
  tcm_fifo_if.store q
);
  import tcm_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // pointer arithmetic relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
    $error("tcm_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////////
  // status and handshake: extra pointer bit tells full from empty
  assign full        = (wr_ptr ^ rd_ptr) == {1'b1, {AW{1'b0}}};
  assign empty       = wr_ptr == rd_ptr;
  assign push        = q.in_valid && !full;
  assign pop         = q.out_ready && !empty;
  assign q.in_ready  = !full;
  assign q.out_valid = !empty;
  assign q.out_data  = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage, no reset needed since empty hides stale words
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= q.in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_fifo_full_stall:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      full |-> !q.in_ready ##1 (wr_ptr == $past(wr_ptr)))
    else $error("queue accepted a word while full");

  a_fifo_pop_order:
    assert property (@(posedge ref_clk) disable iff (!rstn)
      (q.out_valid && q.out_ready) |=> rd_ptr == $past(rd_ptr) + 1'b1)
    else $error("queue read pointer did not advance on pop");
endmodule

// ===== hdl/tcm_switch_ctrl.sv
// per-channel output control of a 256-channel time-slot switch
// Function
// - control-out bit level follows stored control bit
// - all 256 control bits shifted out each frame
// - control bit leads its channel by one
// - stream n channel c in c-1, bit n
// - bit 6 picks variable or constant delay
// - control memory left uninitialised at power-up
// - bit 0 enables channel driver when gate high
// - message bit or global enable sends source byte
// - otherwise source byte addresses switched input data
// - low five bits pick source channel
// - high three bits pick source stream
// - gate low forces every stream output high-impedance
// - global message enable forces message and enable
// - control stream sent once per frame
`timescale 1ns/1ps
`include "tcm_defines.svh"
module tcm_switch_ctrl #(
  parameter int FIFO_DEPTH = `TCM_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // serial timing pins
  input  wire logic                 bit_clk_pin,
  input  wire logic                 frame_start_n_pin,
  // serial streams
  input  wire logic [7:0]           stream_in,
  output logic [7:0]                stream_out,
  output logic [7:0]                stream_oe,
  output logic                      serial_control_out,
  // global controls
  input  wire logic                 global_output_gate,
  input  wire logic                 global_message_enable,
  // processor port
  input  wire logic                 cpu_req,
  input  wire logic                 cpu_write,
  input  wire tcm_pkg::tcm_mem_sel_t cpu_mem_sel,
  input  wire logic [7:0]           cpu_addr,
  input  wire logic [7:0]           cpu_wdata,
  output logic [7:0]                cpu_rdata,
  output logic                      cpu_ack
);
  import tcm_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("tcm_switch_ctrl: FIFO_DEPTH too small");
  end

  logic [7:0]     ctrl_mem [256];
  logic [7:0]     src_mem  [256];
  logic [7:0]     dmem     [2][8][32];
  logic [7:0]     in_shift [8];
  logic [10:0]    pin_meta;
  logic [10:0]    pin_sync;
  logic           bclk_prev;
  logic           bit_stb;
  logic           frame_hit;
  logic           chan_start;
  logic [2:0]     bit_cnt;
  logic [4:0]     ch_cnt;
  logic           bank;
  logic [2:0]     next_bit;
  logic [4:0]     next_ch;
  logic           fetch_on;
  logic [2:0]     fetch_idx;
  logic [4:0]     t_ch;
  logic [7:0]     ctrl_rd;
  logic [7:0]     src_rd;
  logic [7:0]     dmem_rd;
  logic [7:0]     cso_word;
  logic           msg;
  logic           rd_bank;
  logic [7:0]     out_pre  [8];
  logic [7:0]     out_cur  [8];
  logic [7:0]     oe_pre;
  logic [7:0]     oe_cur;
  logic [7:0]     cso_pre;
  logic [7:0]     cso_vec;
  logic [7:0]     sel_cso;
  logic [7:0]     sel_oe;
  tcm_cpu_state_t cpu_state;
  tcm_wr_t        wr_word;

  tcm_fifo_if #(.WIDTH($bits(tcm_wr_t))) wq ();

  tcm_fifo #(
    .WIDTH ($bits(tcm_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .q       (wq.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage feeds logic
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta  <= `TCM_PIN_RST;
      pin_sync  <= `TCM_PIN_RST;
      bclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {global_output_gate, frame_start_n_pin, bit_clk_pin, stream_in};
      pin_sync  <= pin_meta;
      bclk_prev <= pin_sync[`TCM_PIN_BCLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit and channel timing; frame pulse realigns to channel 0 bit 0
  always_comb begin
    bit_stb    = pin_sync[`TCM_PIN_BCLK] && !bclk_prev;
    frame_hit  = !pin_sync[`TCM_PIN_FRAME];
    next_bit   = frame_hit ? 3'h0 : bit_cnt + 3'h1;
    next_ch    = frame_hit ? 5'h00 : ((bit_cnt == 3'h7) ? ch_cnt + 5'h01 : ch_cnt);
    chan_start = bit_stb && (next_bit == 3'h0);
  end

  // counters and frame bank toggle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt <= 3'h0;
      ch_cnt  <= 5'h00;
      bank    <= 1'b0;
    end else if (bit_stb) begin
      bit_cnt <= next_bit;
      ch_cnt  <= next_ch;
      if (frame_hit) begin
        bank <= ~bank;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input deserialisers, msb first, one frame bank written per frame
  always_ff @(posedge ref_clk) begin
    if (bit_stb) begin
      for (int s = 0; s < 8; s++) begin
        in_shift[s] <= {in_shift[s][6:0], pin_sync[s]};
        if (bit_cnt == 3'h7) begin
          dmem[bank][s][ch_cnt] <= {in_shift[s][6:0], pin_sync[s]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch pass: data for the next channel, control bits one further ahead
  always_comb begin
    t_ch     = ch_cnt + 5'h01;
    ctrl_rd  = ctrl_mem[{fetch_idx, t_ch}];
    src_rd   = src_mem[{fetch_idx, t_ch}];
    cso_word = ctrl_mem[{fetch_idx, 5'(ch_cnt + 5'h02)}];
    msg      = ctrl_rd[`TCM_CCM_MC] || global_message_enable;
    // constant delay always reads last complete frame; variable takes the
    // freshest byte, so channel 0 paths in both modes run one frame longer
    if (ctrl_rd[`TCM_CCM_VC]) begin
      rd_bank = ~bank;
    end else begin
      rd_bank = (src_rd[`TCM_SRC_CH_MSB:`TCM_SRC_CH_LSB] < ch_cnt) ? bank : ~bank;
    end
    dmem_rd = dmem[rd_bank][src_rd[`TCM_SRC_STR_MSB:`TCM_SRC_STR_LSB]]
                  [src_rd[`TCM_SRC_CH_MSB:`TCM_SRC_CH_LSB]];
  end

  // fetch sequencer and prepared values, one stream per cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_on  <= 1'b0;
      fetch_idx <= 3'h0;
      out_pre   <= '{default: 8'h00};
      oe_pre    <= 8'h00;
      cso_pre   <= 8'h00;
    end else begin
      if (chan_start) begin
        fetch_on  <= 1'b1;
        fetch_idx <= 3'h0;
      end else if (fetch_on) begin
        fetch_idx <= fetch_idx + 3'h1;
        if (fetch_idx == 3'h7) begin
          fetch_on <= 1'b0;
        end
      end
      if (fetch_on) begin
        out_pre[fetch_idx] <= msg ? src_rd : dmem_rd;
        oe_pre[fetch_idx]  <= ctrl_rd[`TCM_CCM_OE];
        cso_pre[fetch_idx] <= cso_word[`TCM_CCM_CSO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel boundary: prepared values become current
  always_comb begin
    sel_cso = chan_start ? cso_pre : cso_vec;
    sel_oe  = chan_start ? oe_pre : oe_cur;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_cur <= '{default: 8'h00};
      oe_cur  <= 8'h00;
      cso_vec <= 8'h00;
    end else if (chan_start) begin
      out_cur <= out_pre;
      oe_cur  <= oe_pre;
      cso_vec <= cso_pre;
    end
  end

  // serial outputs; control bit k in a channel belongs to stream k
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stream_out         <= 8'h00;
      serial_control_out <= 1'b0;
    end else if (bit_stb) begin
      for (int s = 0; s < 8; s++) begin
        stream_out[s] <= chan_start ? out_pre[s][3'h7 - next_bit] : out_cur[s][3'h7 - next_bit];
      end
      serial_control_out <= sel_cso[next_bit];
    end
  end

  // drivers: gate low wins over every enable bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stream_oe <= 8'h00;
    end else if (!pin_sync[`TCM_PIN_GATE]) begin
      stream_oe <= 8'h00;
    end else begin
      stream_oe <= sel_oe | {8{global_message_enable}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // processor port: writes queue up, reads answer directly
  assign wq.in_valid  = (cpu_state == TCM_CPU_IDLE) && cpu_req && cpu_write;
  assign wq.in_data   = {cpu_mem_sel, cpu_addr, cpu_wdata};
  assign wq.out_ready = !fetch_on;  // fetch pass owns the memories
  assign wr_word      = tcm_wr_t'(wq.out_data);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_state <= TCM_CPU_IDLE;
      cpu_ack   <= 1'b0;
      cpu_rdata <= 8'h00;
    end else begin
      unique case (cpu_state)
        TCM_CPU_IDLE: begin
          if (cpu_req && (!cpu_write || wq.in_ready)) begin
            cpu_ack   <= 1'b1;
            cpu_state <= TCM_CPU_DONE;
            if (!cpu_write) begin
              cpu_rdata <= (cpu_mem_sel == TCM_MEM_CONTROL) ? ctrl_mem[cpu_addr] : src_mem[cpu_addr];
            end
          end
        end
        TCM_CPU_DONE: begin
          if (!cpu_req) begin
            cpu_ack   <= 1'b0;
            cpu_state <= TCM_CPU_IDLE;
          end
        end
        default: cpu_state <= TCM_CPU_IDLE;
      endcase
    end
  end

  // memory writes; contents carry no reset so power-up state is arbitrary
  always_ff @(posedge ref_clk) begin
    if (wq.out_valid && wq.out_ready) begin
      if (wr_word.sel == TCM_MEM_CONTROL) begin
        ctrl_mem[wr_word.addr] <= wr_word.data;
      end else begin
        src_mem[wr_word.addr] <= wr_word.data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_chan_start;
    chan_start;
  endsequence

  sequence s_fetch_pass;
    fetch_on [*8] ##1 !fetch_on;
  endsequence

  a_fetch_pass_len:
    assert property (s_chan_start |=> s_fetch_pass)
    else $error("fetch pass did not cover eight streams");

  // case equality: control words not yet programmed are unknown after power-up
  a_cso_bit_level:
    assert property (bit_stb |=> serial_control_out === cso_vec[bit_cnt])
    else $error("control out bit does not match its slot");

  a_cso_ahead:
    assert property (s_chan_start |=> cso_vec === $past(cso_pre))
    else $error("control bits not advanced at channel start");

  a_frame_wrap:
    assert property ((bit_stb && frame_hit) |=> (bit_cnt == 3'h0) && (ch_cnt == 5'h00))
    else $error("frame pulse did not realign the channel count");

  a_gate_off:
    assert property (!pin_sync[`TCM_PIN_GATE] |=> stream_oe == 8'h00)
    else $error("output driven while gate low");

  a_msg_force_oe:
    assert property ((pin_sync[`TCM_PIN_GATE] && global_message_enable) |=> stream_oe == 8'hff)
    else $error("message enable did not force drivers on");

  a_msg_byte:
    assert property ((fetch_on && msg) |=> out_pre[$past(fetch_idx)] == $past(src_rd))
    else $error("message channel did not take the source byte");

  a_conn_byte:
    assert property ((fetch_on && !msg) |=> out_pre[$past(fetch_idx)] == $past(dmem_rd))
    else $error("connected channel did not take switched data");

  a_const_bank:
    assert property ((fetch_on && ctrl_rd[`TCM_CCM_VC]) |-> rd_bank == !bank)
    else $error("constant delay read the frame being written");

  a_cpu_ack_bound:
    assert property (($rose(cpu_req) && cpu_state == TCM_CPU_IDLE) |-> ##[1:40] cpu_ack)
    else $error("processor access not acknowledged");
endmodule

// ===== sim/tcm_far_end.sv
// far-end serial timing source and line capture for the switch bench
`timescale 1ns/1ps
module tcm_far_end (
  // serial timing and data towards the switch
  output logic            bit_clk_pin,
  output logic            frame_start_n_pin,
  output logic [7:0]      stream_in,
  // switch outputs seen on the line
  input  wire logic [7:0] stream_out,
  input  wire logic [7:0] stream_oe,
  input  wire logic       serial_control_out
);
  int unsigned pos;
  int unsigned frames;
  logic [7:0]  out_cap [8][32];
  logic        oe_cap  [8][32];
  logic [7:0]  ctl_cap [32];

  // byte inverts every other frame, so the two delay modes give different values
  function automatic logic [7:0] in_pattern(input int s, input int c, input int f);
    return {c[4:0], s[2:0]} ^ 8'ha5 ^ {8{f[0]}};
  endfunction

  // the strobe that sees the frame pulse still samples the last bit of the
  // previous frame, so input data runs one bit behind the pulse
  task automatic drive(input int unsigned p);
    logic [7:0]  b;
    int unsigned q;
    q = (p + 255) % 256;
    for (int s = 0; s < 8; s++) begin
      b = in_pattern(s, q / 8, frames - (p == 0));
      stream_in[s] = b[7 - q % 8];
    end
    frame_start_n_pin = (p != 0);
  endtask

  // set up the first bit before the clock starts
  initial begin
    bit_clk_pin = 1'b0;
    pos = 0;
    frames = 0;
    drive(0);
  end

  // 16 reference cycles a bit, room for the per-channel fetch pass
  always #64 bit_clk_pin = ~bit_clk_pin;

  // capture mid-bit, long after the registered outputs settle, then set up the next bit
  always @(negedge bit_clk_pin) begin
    for (int s = 0; s < 8; s++) begin
      out_cap[s][pos / 8][7 - pos % 8] = stream_out[s];
      if (pos % 8 == 3) begin
        oe_cap[s][pos / 8] = stream_oe[s];
      end
    end
    ctl_cap[pos / 8][pos % 8] = serial_control_out;
    if (pos == 255) begin
      frames++;
    end
    pos = (pos + 1) % 256;
    drive(pos);
  end
endmodule

// ===== sim/tb_tdm_connection_memory_control.sv
// self-checking bench for the time-slot switch output control block
`timescale 1ns/1ps
module tb_tdm_connection_memory_control;
  import tcm_pkg::*;
  logic         ref_clk;
  logic         rstn;
  logic         bit_clk_pin;
  logic         frame_start_n_pin;
  logic [7:0]   stream_in;
  logic [7:0]   stream_out;
  logic [7:0]   stream_oe;
  logic         serial_control_out;
  logic         global_output_gate;
  logic         global_message_enable;
  logic         cpu_req;
  logic         cpu_write;
  tcm_mem_sel_t cpu_mem_sel;
  logic [7:0]   cpu_addr;
  logic [7:0]   cpu_wdata;
  logic [7:0]   cpu_rdata;
  logic         cpu_ack;
  int           mismatches;
  int           checks;

  // small queue so the write path runs near full
  tcm_switch_ctrl #(.FIFO_DEPTH(4)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .bit_clk_pin(bit_clk_pin), .frame_start_n_pin(frame_start_n_pin),
    .stream_in(stream_in), .stream_out(stream_out), .stream_oe(stream_oe),
    .serial_control_out(serial_control_out), .global_output_gate(global_output_gate),
    .global_message_enable(global_message_enable), .cpu_req(cpu_req), .cpu_write(cpu_write),
    .cpu_mem_sel(cpu_mem_sel), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack)
  );

  // serial far end
  tcm_far_end far (
    .bit_clk_pin(bit_clk_pin), .frame_start_n_pin(frame_start_n_pin), .stream_in(stream_in),
    .stream_out(stream_out), .stream_oe(stream_oe), .serial_control_out(serial_control_out)
  );

  // 125 MHz reference clock
  always #4 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // control word per address: mixes delay, message, control-out and enable bits
  function automatic logic [7:0] ctl_of(input logic [7:0] a);
    return {1'b0, a[4], 3'b000, a[1] & a[6], a[2] ^ a[5], a[0] | a[3]};
  endfunction

  // source word: rotation, so stream and channel fields both move
  function automatic logic [7:0] src_of(input logic [7:0] a);
    return {a[2:0], a[7:3]};
  endfunction

  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // one processor access: hold request until ack, drop it, wait for ack low
  task automatic cpu_op(input logic wr, input tcm_mem_sel_t sel, input logic [7:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    cpu_req     <= 1'b1;
    cpu_write   <= wr;
    cpu_mem_sel <= sel;
    cpu_addr    <= addr;
    cpu_wdata   <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpu_ack !== 1'b1 && n < 100);
    rd = cpu_rdata;
    cpu_req <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cpu_ack !== 1'b0 && n < 200);
    check(n < 200, "processor handshake stalled");
  endtask

  // waiting three boundaries leaves one whole frame captured after any change
  task automatic wait_frames(input int unsigned n);
    int unsigned f0;
    f0 = far.frames;
    while (far.frames < f0 + n) begin
      @(posedge ref_clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // both memories keep what was written at first, last and a middle location
  task automatic t_mem_rw();
    logic [7:0] rd;
    logic [7:0] a;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h6b;
      // source word lands first so a message channel never shows an unwritten byte
      cpu_op(1'b1, TCM_MEM_SOURCE, a, a ^ 8'h3c, rd);
      cpu_op(1'b1, TCM_MEM_CONTROL, a, ~a, rd);
      repeat (12) @(posedge ref_clk);
      cpu_op(1'b0, TCM_MEM_CONTROL, a, 8'h00, rd);
      check(rd === ~a, "control word read back");
      cpu_op(1'b0, TCM_MEM_SOURCE, a, 8'h00, rd);
      check(rd === (a ^ 8'h3c), "source word read back");
    end
  endtask

  // every channel programmed while the gate is still low
  task automatic program_all();
    logic [7:0] rd;
    for (int a = 0; a < 256; a++) begin
      cpu_op(1'b1, TCM_MEM_SOURCE, 8'(a), src_of(8'(a)), rd);
      cpu_op(1'b1, TCM_MEM_CONTROL, 8'(a), ctl_of(8'(a)), rd);
    end
    repeat (12) @(posedge ref_clk);
  endtask

  // gate low: no driver on; control stream already runs, one channel early
  task automatic t_gate_low();
    logic [7:0] w;
    wait_frames(3);
    for (int c = 0; c < 32; c++) begin
      for (int k = 0; k < 8; k++) begin
        w = ctl_of({k[2:0], 5'(c + 1)});
        check(far.oe_cap[k][c] === 1'b0, "driver on while gate low");
        check(far.ctl_cap[c][k] === w[1], "control stream bit");
      end
    end
  endtask

  // gate high: per-channel enable, message bytes and switched bytes
  task automatic t_gate_high();
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] src;
    int         f;
    global_output_gate <= 1'b1;
    wait_frames(3);
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 32; c++) begin
        a = {s[2:0], c[4:0]};
        w = ctl_of(a);
        src = src_of(a);
        check(far.oe_cap[s][c] === w[0], "channel enable");
        if (w[0] && w[2]) begin
          check(far.out_cap[s][c] === src, "message byte");
        end else if (w[0]) begin
          // fetched one channel early; variable takes this frame only for sources already received
          f = far.frames - 1 - (c == 0) - ((!w[6] && src[4:0] < 5'(c + 31)) ? 0 : 1);
          check(far.out_cap[s][c] === far.in_pattern(src[7:5], src[4:0], f), "switched byte");
        end
      end
    end
  endtask

  // global message enable: every channel driven with its source word
  task automatic t_msg_all();
    global_message_enable <= 1'b1;
    wait_frames(3);
    for (int s = 0; s < 8; s++) begin
      for (int c = 0; c < 32; c++) begin
        check(far.oe_cap[s][c] === 1'b1, "forced enable");
        check(far.out_cap[s][c] === src_of({s[2:0], c[4:0]}), "forced message");
      end
    end
    global_message_enable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // gate held low from power-up until programming is done
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    global_output_gate = 1'b0;
    global_message_enable = 1'b0;
    cpu_req = 1'b0;
    cpu_write = 1'b0;
    cpu_mem_sel = TCM_MEM_SOURCE;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    mismatches = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    // two whole frames fill both data banks before any connection reads them
    wait_frames(2);
    t_mem_rw();
    program_all();
    t_gate_low();
    t_gate_high();
    t_msg_all();
    end_sim();
  end

  // watchdog: about 1.7 times the expected run
  initial begin
    #600000;
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule
